//--- hdl/ttf_channel.v
// one filter channel of the digitizer card with its link framer
// Overview of operation
// - samples are 10-bit unsigned, four per crossing
// - stream decimated by two; kept phase selectable per tower
// - per channel capture on either phase of the 4x sample clock
// - matched filter at 2x crossing rate, 8 taps, zero taps unused
// - 10x6 bit products summed to 19 bits, 16 bits kept
// - 3-point peak detector follows; static baseline only
// - peak output decimated to one per crossing, cut to 11 bits
// - 11-bit result addresses lookup table giving 8-bit energy
// - decimation, coefficients and table writable while running
// - 1Kx18 history: filter half and raw+energy half, 512 each
// - buffer written at 8x: filter four times, raw+energy four times
// - history spans 128 crossings and can be frozen
// - test mode replays preloaded raw samples into the filter
// - three identical links carry the energies each crossing
// - link also carries crossing count, framing, size flag, parity
// - 16-bit pseudo-random or constant may replace filter output
// - all timing derived from the single crossing timebase
// - init flag starts initialization, acknowledge when complete
// - local crossing and turn counters for sync checking
// - qualified accept freezes history until software resumes
// - first level trigger busy and error reported back
// - slave port loads coefficients, tables, reads raw samples
// - raw send switches link to history and flags 10-bit frames
`timescale 1ns/1ps
`include "ttf_defines.vh"
module ttf_channel
(
   // clock, reset, enable
   input wire clk_sys,
   input wire reset_n,
   input wire ce,
   // converter samples, one taken every second clock
   input wire [9:0] adc_data,
   // command link pins
   input wire init_pin,
   input wire accept_pin,
   input wire qual_pin,
   input wire turn_pin,
   // command link answers
   output wire init_ack,
   output wire l1_busy,
   output wire l1_error,
   // configuration
   input wire edge_sel,
   input wire dec_sel,
   input wire [47:0] coef_flat,
   input wire test_mode,
   input wire [1:0] src_sel,
   input wire [7:0] const_val,
   input wire raw_send_en,
   input wire [7:0] raw_burst_len,
   input wire qual_en,
   input wire sw_trig,
   input wire resume,
   // lookup table write
   input wire lut_we,
   input wire [10:0] lut_addr,
   input wire [7:0] lut_wdata,
   // history buffer access
   input wire hb_we,
   input wire [9:0] hb_addr,
   input wire [17:0] hb_wdata,
   output reg [17:0] hb_rdata_ff,
   // status
   output wire frozen,
   output wire link_drop,
   output wire [11:0] xing_count,
   output wire [15:0] turn_count,
   // output links
   input wire link_ready,
   output wire [2:0] link0_data,
   output wire [2:0] link1_data,
   output wire [2:0] link2_data,
   output wire link_frame,
   output wire link_valid
);

localparam ST_RUN = 3'b001;
localparam ST_INIT = 3'b010;
localparam ST_ACK = 3'b100;
localparam [31:0] INIT_CYC = `TTF_INIT_CYC;

integer i;
integer j;
reg [3:0] s1_ff, s2_ff, s3_ff, st_ff;
wire [3:0] nxt_st;
wire [3:0] rise;
reg [2:0] state_ff, nxt_state;
reg [3:0] icnt_ff;
wire clr;
wire run;
reg [2:0] ph_ff;
wire slot_end, cap, keep;
reg [9:0] smp_ff;
reg [9:0] tap_ff [0:7];
reg keep_d_ff;
reg [18:0] acc;
reg [15:0] filt_ff, f1_ff, f2_ff, pk_ff;
reg [17:0] filt_hb_ff;
reg [10:0] res_ff;
reg [7:0] en_ff;
reg [7:0] lut_mem [0:`TTF_LUT_D-1];
reg [17:0] hb_mem [0:`TTF_HB_D-1];
reg [8:0] wp_ff, rep_ptr_ff, rb_ptr_ff;
reg [15:0] prng_ff;
reg [11:0] xing_ff, xsnap_ff;
reg [15:0] turn_ff;
reg frozen_ff, nxt_frozen;
reg err_ff, drop_ff;
reg [7:0] burst_ff;
reg bq_ff;
wire [9:0] rep_smp, rb_smp, in_smp;
wire qual_hit, raw_hit, frz_set, frz_clr, burst_on, burst_done;
reg [7:0] sel_e;
wire [9:0] fdata;
wire [22:0] fbody;
wire push, f_ready, f_valid, f_pop;
wire [23:0] f_out;
reg [23:0] ser_ff;
reg [3:0] beat_ff;
reg [2:0] lane_ff;
reg lfrm_ff, lval_ff;
wire rec_we;
wire [9:0] rec_addr;
wire [17:0] rec_data;

// pin synchroniser; a bit changes once stages two and three agree
assign nxt_st = (s2_ff & s3_ff) | (st_ff & (s2_ff | s3_ff));
assign rise = nxt_st & ~st_ff;

always @(posedge clk_sys or negedge reset_n)
begin
   if (!reset_n)
   begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      s3_ff <= 4'h0;
      st_ff <= 4'h0;
   end
   else if (ce)
   begin
      s1_ff <= {turn_pin, qual_pin, accept_pin, init_pin};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      st_ff <= nxt_st;
   end
end

// init sequencing
always @*
begin
   nxt_state = state_ff;
   case (state_ff)
      ST_RUN:
         if (rise[0])
            nxt_state = ST_INIT;
      ST_INIT:
         if (icnt_ff == 4'h0)
            nxt_state = ST_ACK;
      ST_ACK:
         nxt_state = ST_RUN;
      default:
         nxt_state = ST_INIT;
   endcase
end

always @(posedge clk_sys or negedge reset_n)
begin
   if (!reset_n)
   begin
      state_ff <= ST_INIT;
      icnt_ff <= INIT_CYC[3:0];
   end
   else if (ce)
   begin
      state_ff <= nxt_state;
      if (state_ff != ST_INIT)
         icnt_ff <= INIT_CYC[3:0];
      else if (icnt_ff != 4'h0)
         icnt_ff <= icnt_ff - 4'h1;
   end
end

assign clr = (state_ff == ST_INIT);
assign run = (state_ff == ST_RUN);
assign init_ack = (state_ff == ST_ACK);

// slot phase: eight slots per crossing
assign slot_end = run & (ph_ff == `TTF_SLOT_LAST);
assign cap = run & (ph_ff[0] == edge_sel);
assign keep = cap & (ph_ff[1] == dec_sel);

// test replay from the raw half
assign rep_smp = hb_mem[{1'b1, rep_ptr_ff}][17:8];
assign in_smp = test_mode ? rep_smp : adc_data;

// matched filter
always @*
begin
   acc = 19'h0;
   for (i = 0; i < `TTF_TAPS; i = i + 1)
      acc = acc + tap_ff[i] * coef_flat[i*6 +: 6];
end

always @(posedge clk_sys or negedge reset_n)
begin
   if (!reset_n)
   begin
      ph_ff <= 3'h0;
      smp_ff <= 10'h000;
      keep_d_ff <= 1'b0;
      rep_ptr_ff <= 9'h000;
      for (j = 0; j < `TTF_TAPS; j = j + 1)
         tap_ff[j] <= 10'h000;
   end
   else if (ce)
   begin
      ph_ff <= run ? ph_ff + 3'h1 : 3'h0;
      keep_d_ff <= keep;
      if (clr)
      begin
         rep_ptr_ff <= 9'h000;
         for (j = 0; j < `TTF_TAPS; j = j + 1)
            tap_ff[j] <= 10'h000;
      end
      else
      begin
         if (cap)
            smp_ff <= in_smp;
         if (cap & test_mode)
            rep_ptr_ff <= rep_ptr_ff + 9'h001;
         if (keep)
         begin
            tap_ff[0] <= in_smp;
            for (j = 1; j < `TTF_TAPS; j = j + 1)
               tap_ff[j] <= tap_ff[j-1];
         end
      end
   end
end

// filter output, peak detect, decimate, truncate
always @(posedge clk_sys or negedge reset_n)
begin
   if (!reset_n)
   begin
      filt_ff <= 16'h0000;
      filt_hb_ff <= 18'h00000;
      f1_ff <= 16'h0000;
      f2_ff <= 16'h0000;
      pk_ff <= 16'h0000;
      res_ff <= 11'h000;
      en_ff <= 8'h00;
   end
   else if (ce)
   begin
      if (keep_d_ff)
      begin
         filt_ff <= acc[`TTF_KEEP_HI:`TTF_KEEP_LO];
         filt_hb_ff <= acc[18:1];
         f2_ff <= f1_ff;
         f1_ff <= filt_ff;
         // middle point must top the older neighbour and at least equal the newer
         pk_ff <= (f1_ff > f2_ff && f1_ff >= filt_ff) ? f1_ff : 16'h0000;
      end
      if (slot_end)
         res_ff <= {|pk_ff[`TTF_OVF_HI:`TTF_OVF_LO],
            pk_ff[`TTF_SIG_HI:`TTF_SIG_LO]};
      if (run & (ph_ff == 3'h0))
         en_ff <= lut_mem[res_ff];
   end
end

// lookup table, writable at any time
always @(posedge clk_sys)
begin
   if (ce & lut_we)
      lut_mem[lut_addr] <= lut_wdata;
end

// history: even slots filter half, odd slots raw+energy half
assign rec_we = run & ~frozen_ff & ~(ph_ff[0] & test_mode);
assign rec_addr = {ph_ff[0], wp_ff};
assign rec_data = ph_ff[0] ? {smp_ff, en_ff} : filt_hb_ff;

always @(posedge clk_sys)
begin
   if (ce)
   begin
      if (hb_we & (frozen_ff | test_mode))
         hb_mem[hb_addr] <= hb_wdata;
      else if (rec_we)
         hb_mem[rec_addr] <= rec_data;
      hb_rdata_ff <= hb_mem[hb_addr];
   end
end

// first level trigger handling
assign burst_on = (burst_ff != 8'h00);
assign qual_hit = rise[1] & nxt_st[2] & qual_en;
assign raw_hit = rise[1] & raw_send_en & ~frozen_ff & ~burst_on;
assign frz_set = (qual_hit & ~frozen_ff) | sw_trig | raw_hit;
assign burst_done = burst_on & (burst_ff == 8'h01) & push;
assign frz_clr = resume | (burst_done & ~bq_ff);

always @*
begin
   nxt_frozen = frozen_ff;
   if (frz_set)
      nxt_frozen = 1'b1;
   else if (frz_clr)
      nxt_frozen = 1'b0;
end

always @(posedge clk_sys or negedge reset_n)
begin
   if (!reset_n)
   begin
      frozen_ff <= 1'b0;
      err_ff <= 1'b0;
      burst_ff <= 8'h00;
      bq_ff <= 1'b0;
      rb_ptr_ff <= 9'h000;
      xsnap_ff <= 12'h000;
      wp_ff <= 9'h000;
   end
   else if (ce)
   begin
      if (clr)
      begin
         frozen_ff <= 1'b0;
         err_ff <= 1'b0;
         burst_ff <= 8'h00;
         wp_ff <= 9'h000;
      end
      else
      begin
         frozen_ff <= nxt_frozen;
         if (qual_hit & frozen_ff)
            err_ff <= 1'b1;
         if (rec_we & ph_ff[0])
            wp_ff <= wp_ff + 9'h001;
         if (raw_hit)
         begin
            burst_ff <= raw_burst_len;
            bq_ff <= qual_hit;
            rb_ptr_ff <= wp_ff - {1'b0, raw_burst_len};
            xsnap_ff <= xing_ff;
         end
         else if (burst_on & push)
         begin
            burst_ff <= burst_ff - 8'h01;
            rb_ptr_ff <= rb_ptr_ff + 9'h001;
         end
      end
   end
end

assign frozen = frozen_ff;
assign l1_busy = frozen_ff | burst_on;
assign l1_error = err_ff;

// crossing and turn counters, pseudo-random source
always @(posedge clk_sys or negedge reset_n)
begin
   if (!reset_n)
   begin
      xing_ff <= 12'h000;
      turn_ff <= 16'h0000;
      prng_ff <= `TTF_PRNG_RST;
   end
   else if (ce)
   begin
      if (clr)
      begin
         xing_ff <= 12'h000;
         turn_ff <= 16'h0000;
         prng_ff <= `TTF_PRNG_RST;
      end
      else
      begin
         if (rise[3])
         begin
            xing_ff <= 12'h000;
            turn_ff <= turn_ff + 16'h0001;
         end
         else if (slot_end)
            xing_ff <= xing_ff + 12'h001;
         if (slot_end)
            prng_ff <= (prng_ff >> 1) ^
               (prng_ff[0] ? `TTF_PRNG_POLY : 16'h0000);
      end
   end
end

assign xing_count = xing_ff;
assign turn_count = turn_ff;

// frame assembly: parity, size flag, crossing count, data
always @*
begin
   case (src_sel)
      `TTF_SRC_FILT:
         sel_e = en_ff;
      `TTF_SRC_CONST:
         sel_e = const_val;
      `TTF_SRC_PRNG:
         sel_e = prng_ff[7:0];
      default:
         sel_e = en_ff;
   endcase
end

assign rb_smp = hb_mem[{1'b1, rb_ptr_ff}][17:8];
assign fdata = burst_on ? rb_smp : {2'b00, sel_e};
assign fbody = {burst_on, burst_on ? xsnap_ff : xing_ff, fdata};
assign push = run & (ph_ff == `TTF_SLOT_PUSH) & f_ready;

always @(posedge clk_sys or negedge reset_n)
begin
   if (!reset_n)
      drop_ff <= 1'b0;
   else if (ce)
   begin
      if (run & (ph_ff == `TTF_SLOT_PUSH) & ~f_ready)
         drop_ff <= 1'b1;
      else if (clr)
         drop_ff <= 1'b0;
   end
end

assign link_drop = drop_ff;

ttf_fifo #(
   .W(`TTF_FRM_W),
   .D(`TTF_FIFO_D),
   .AW(`TTF_FIFO_AW)
) u_fifo (
   .clk_sys(clk_sys),
   .reset_n(reset_n),
   .ce(ce),
   .in_valid(push),
   .in_ready(f_ready),
   .in_data({^fbody, fbody}),
   .out_valid(f_valid),
   .out_ready(f_pop),
   .out_data(f_out)
);

// serializer: eight 3-bit beats, lsb first, frame on beat 0
assign f_pop = (beat_ff == 4'h0) | ((beat_ff == 4'h1) & link_ready);

always @(posedge clk_sys or negedge reset_n)
begin
   if (!reset_n)
   begin
      ser_ff <= 24'h000000;
      beat_ff <= 4'h0;
      lane_ff <= 3'h0;
      lfrm_ff <= 1'b0;
      lval_ff <= 1'b0;
   end
   else if (ce)
   begin
      // beat and frame markers stand one cycle only
      lval_ff <= 1'b0;
      lfrm_ff <= 1'b0;
      if (beat_ff != 4'h0 && link_ready)
      begin
         lane_ff <= ser_ff[2:0];
         lfrm_ff <= (beat_ff == `TTF_BEATS);
         lval_ff <= 1'b1;
         ser_ff <= ser_ff >> `TTF_LANE_W;
         beat_ff <= beat_ff - 4'h1;
      end
      if (f_valid & f_pop)
      begin
         ser_ff <= f_out;
         beat_ff <= `TTF_BEATS;
      end
   end
end

assign link0_data = lane_ff;
assign link1_data = lane_ff;
assign link2_data = lane_ff;
assign link_frame = lfrm_ff;
assign link_valid = lval_ff;

endmodule

//--- hdl/ttf_defines.vh
// constants of the trigger tower filter channel
`ifndef TTF_DEFINES_VH
`define TTF_DEFINES_VH

// datapath widths
`define TTF_SMP_W 10
`define TTF_COEF_W 6
`define TTF_TAPS 8
`define TTF_ACC_W 19
`define TTF_KEEP_HI 18
`define TTF_KEEP_LO 3
`define TTF_PK_W 16
`define TTF_OVF_HI 15
`define TTF_OVF_LO 14
`define TTF_SIG_HI 13
`define TTF_SIG_LO 4
`define TTF_LUT_AW 11
`define TTF_LUT_D 2048
`define TTF_E_W 8

// history buffer
`define TTF_HB_AW 10
`define TTF_HB_D 1024
`define TTF_HB_DW 18
`define TTF_HB_PW 9

// slot timing: eight slots per crossing
`define TTF_SLOT_LAST 3'h7
`define TTF_SLOT_PUSH 3'h1

// counters and link frame
`define TTF_XING_W 12
`define TTF_TURN_W 16
`define TTF_FRM_W 24
`define TTF_LANE_W 3
`define TTF_BEATS 4'h8
`define TTF_FIFO_D 8
`define TTF_FIFO_AW 3

// output source select
`define TTF_SRC_FILT 2'h0
`define TTF_SRC_CONST 2'h1
`define TTF_SRC_PRNG 2'h2

// pseudo-random generator
`define TTF_PRNG_RST 16'hACE1
`define TTF_PRNG_POLY 16'hB400

// initialization time
`define TTF_CLK_NS 100
`define TTF_INIT_NS 1000
`define TTF_INIT_CYC ((`TTF_INIT_NS + `TTF_CLK_NS - 1) / `TTF_CLK_NS)

`endif

//--- hdl/ttf_fifo.v
// word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ttf_fifo #(
   parameter W = 24,
   parameter D = 8,
   parameter AW = 3
)
(
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   input wire ce,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);

reg [W-1:0] mem_ff [0:D-1];
reg [AW-1:0] wp_ff;
reg [AW-1:0] rp_ff;
reg [AW:0] cnt_ff;
wire push;
wire pop;

assign in_ready = (cnt_ff != D[AW:0]);
assign out_valid = (cnt_ff != {(AW+1){1'b0}});
assign out_data = mem_ff[rp_ff];
assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;

always @(posedge clk_sys)
begin
   if (ce & push)
      mem_ff[wp_ff] <= in_data;
end

always @(posedge clk_sys or negedge reset_n)
begin
   if (!reset_n)
   begin
      wp_ff <= {AW{1'b0}};
      rp_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
   end
   else if (ce)
   begin
      if (push)
         wp_ff <= (wp_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_ff + 1'b1;
      if (pop)
         rp_ff <= (rp_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_ff + 1'b1;
      if (push & ~pop)
         cnt_ff <= cnt_ff + 1'b1;
      else if (pop & ~push)
         cnt_ff <= cnt_ff - 1'b1;
   end
end

endmodule

//--- sim/ttf_link_sink.sv
// link receiver model that paces beats and rebuilds frames
`timescale 1ns/1ps
module ttf_link_sink
(
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   // pacing: 0 prompt, 1 slow, 2 stalled
   input wire [1:0] mode,
   // link lanes
   input wire link_valid,
   input wire link_frame,
   input wire [2:0] link0_data,
   output reg link_ready_ff,
   // rebuilt frames
   output reg [23:0] frame_ff,
   output reg [7:0] n_frames_ff
);
reg [23:0] acc_ff;
reg [2:0] beat_ff;
reg tog_ff;
reg [2:0] b;
reg [23:0] nxt_acc;
always @(posedge clk_sys or negedge reset_n)
begin
   if (!reset_n)
   begin
      {link_ready_ff, tog_ff, beat_ff, acc_ff} <= 29'h0;
      frame_ff <= 24'h000000;
      n_frames_ff <= 8'h00;
   end
   else
   begin
      tog_ff <= ~tog_ff;
      link_ready_ff <= mode == 2'h0 || (mode == 2'h1 && tog_ff);
      if (link_valid)
      begin
         // three bits a beat, lowest bits first
         b = link_frame ? 3'h0 : beat_ff;
         nxt_acc = acc_ff;
         nxt_acc[b * 3 +: 3] = link0_data;
         acc_ff <= nxt_acc;
         beat_ff <= b + 3'h1;
         if (b == 3'h7)
         begin
            frame_ff <= nxt_acc;
            n_frames_ff <= n_frames_ff + 8'h01;
         end
      end
   end
end
endmodule

//--- sim/ttf_channel_properties.sv
// port assertions of the filter channel
`timescale 1ns/1ps
module ttf_channel_properties
(
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   // command link and control
   input wire init_pin,
   input wire accept_pin,
   input wire qual_pin,
   input wire qual_en,
   input wire resume,
   input wire init_ack,
   input wire l1_busy,
   input wire l1_error,
   input wire frozen,
   // link
   input wire link_ready,
   input wire link_valid,
   input wire link_frame,
   input wire [2:0] link0_data,
   input wire [2:0] link1_data,
   input wire [2:0] link2_data
);
default clocking cb @(posedge clk_sys);
endclocking
default disable iff (!reset_n);
sequence qual_accept;
   $rose(accept_pin) && qual_pin && qual_en && !init_pin;
endsequence
sequence quiet_resume;
   !accept_pin [*6] ##0 (frozen && resume);
endsequence
lanes_match_a:
   assert property (link_valid |-> link0_data == link1_data
      && link1_data == link2_data) else $error("lanes differ");
beat_paced_a:
   assert property (link_valid |-> $past(link_ready))
   else $error("beat without ready");
ack_pulse_a:
   assert property (init_ack |=> !init_ack) else $error("ack too long");
frame_spacing_a:
   assert property (link_frame |-> link_valid ##1 !link_frame [*7])
   else $error("frame marker misplaced");
busy_frozen_a:
   assert property (frozen |-> l1_busy) else $error("frozen not busy");
freeze_on_qual_a:
   assert property (qual_accept and !frozen |-> ##[1:6] frozen)
   else $error("qualified accept did not freeze");
error_repeat_a:
   assert property (qual_accept and frozen |-> ##[1:6] l1_error)
   else $error("repeat accept gave no error");
error_cause_a:
   assert property ($rose(l1_error) |-> $past(frozen))
   else $error("error while not frozen");
resume_thaw_a:
   assert property (quiet_resume |=> !frozen) else $error("resume ignored");
endmodule
bind ttf_channel ttf_channel_properties u_props (.clk_sys(clk_sys),
   .reset_n(reset_n), .init_pin(init_pin), .accept_pin(accept_pin),
   .qual_pin(qual_pin), .qual_en(qual_en), .resume(resume),
   .init_ack(init_ack), .l1_busy(l1_busy), .l1_error(l1_error),
   .frozen(frozen), .link_ready(link_ready), .link_valid(link_valid),
   .link_frame(link_frame), .link0_data(link0_data),
   .link1_data(link1_data), .link2_data(link2_data));

//--- sim/tb_ttf_channel.sv
// self-checking bench of the filter channel
`timescale 1ns/1ps
`include "ttf_defines.vh"
module tb_ttf_channel;
reg clk_sys = 0, reset_n = 0, ce = 1, init_pin = 0, accept_pin = 0;
reg qual_pin = 0, turn_pin = 0, edge_sel = 0, dec_sel = 0, test_mode = 0;
reg raw_send_en = 0, qual_en = 1, sw_trig = 0, resume = 0, lut_we = 0;
reg hb_we = 0;
reg [47:0] coef_flat = 48'h041041041041;
reg [1:0] src_sel = 2'h1, sink_mode = 2'h0;
reg [7:0] const_val = 8'h00, raw_burst_len = 8'h02, lut_wdata = 8'h00;
reg [10:0] lut_addr = 11'h000;
reg [9:0] adc_data = 10'h040, hb_addr = 10'h123;
reg [17:0] hb_wdata = 18'h2AB5C;
reg [19:0] rows [0:3];
reg [23:0] w, w2;
reg [15:0] p;
wire init_ack, l1_busy, l1_error, frozen, link_drop, link_ready;
wire link_frame, link_valid;
wire [2:0] link0_data, link1_data, link2_data;
wire [17:0] hb_rdata_ff;
wire [11:0] xing_count;
wire [15:0] turn_count;
wire [23:0] frame_word;
wire [7:0] n_frames;
integer failures = 0, n_compared = 0, cyc = 0, i, n;
ttf_channel dut (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
   .adc_data(adc_data), .init_pin(init_pin), .accept_pin(accept_pin),
   .qual_pin(qual_pin), .turn_pin(turn_pin), .init_ack(init_ack),
   .l1_busy(l1_busy), .l1_error(l1_error), .edge_sel(edge_sel),
   .dec_sel(dec_sel), .coef_flat(coef_flat), .test_mode(test_mode),
   .src_sel(src_sel), .const_val(const_val), .raw_send_en(raw_send_en),
   .raw_burst_len(raw_burst_len), .qual_en(qual_en), .sw_trig(sw_trig),
   .resume(resume), .lut_we(lut_we), .lut_addr(lut_addr),
   .lut_wdata(lut_wdata), .hb_we(hb_we), .hb_addr(hb_addr),
   .hb_wdata(hb_wdata), .hb_rdata_ff(hb_rdata_ff), .frozen(frozen),
   .link_drop(link_drop), .xing_count(xing_count),
   .turn_count(turn_count), .link_ready(link_ready),
   .link0_data(link0_data), .link1_data(link1_data),
   .link2_data(link2_data), .link_frame(link_frame),
   .link_valid(link_valid));
ttf_link_sink sink (.clk_sys(clk_sys), .reset_n(reset_n),
   .mode(sink_mode), .link_valid(link_valid), .link_frame(link_frame),
   .link0_data(link0_data), .link_ready_ff(link_ready),
   .frame_ff(frame_word), .n_frames_ff(n_frames));
always #50 clk_sys = ~clk_sys;
task check(input [23:0] seen, input [23:0] exp);
begin
   n_compared = n_compared + 1;
   if (seen !== exp)
   begin
      failures = failures + 1;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
   end
end
endtask
task step(input integer k);
   integer j;
begin
   for (j = 0; j < k; j = j + 1)
   begin
      @(posedge clk_sys);
      #1;
   end
end
endtask
task next_frame(output [23:0] f);
   reg [7:0] c;
   integer j;
begin
   c = n_frames;
   j = 0;
   while (n_frames === c && j < 40)
   begin
      step(1);
      j = j + 1;
   end
   f = frame_word;
   check(j < 40, 24'h1);
   check(^f, 24'h0);
end
endtask
task wait_ack;
begin
   n = 0;
   while (init_ack !== 1'b1 && n < 40)
   begin
      step(1);
      n = n + 1;
   end
end
endtask
task give_verdict;
begin
   $display("compared %0d failures %0d", n_compared, failures);
   if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
   else
      $display("Testbench failed");
   $finish;
end
endtask
always @(posedge clk_sys)
begin
   cyc <= cyc + 1;
   if (cyc == 6000)
   begin
      failures = failures + 1;
      give_verdict;
   end
end
initial
begin
   // source, capture phase, kept sample, value, energy expected
   rows[0] = {2'h1, 2'h0, 8'h5A, 8'h5A};
   rows[1] = {2'h1, 2'h3, 8'hA5, 8'hA5};
   rows[2] = {2'h0, 2'h1, 8'h3C, 8'h3C};
   rows[3] = {2'h3, 2'h2, 8'hC3, 8'hC3};
   step(4);
   check({frozen, l1_busy, l1_error, init_ack, link_valid}, 24'h0);
   reset_n = 1;
   wait_ack;
   check(n >= 9 && n <= 12, 24'h1);
   for (i = 0; i < 4; i = i + 1)
   begin
      {src_sel, edge_sel, dec_sel, const_val} = rows[i][19:8];
      lut_wdata = rows[i][15:8];
      lut_we = 1;
      step(1);
      lut_we = 0;
      step(160);
      next_frame(w);
      check(w[7:0], rows[i][7:0]);
      check(w[22], 24'h0);
   end
   next_frame(w);
   next_frame(w2);
   check(w2[21:10], w[21:10] + 12'h001);
   qual_pin = 1;
   accept_pin = 1;
   step(8);
   check({frozen, l1_busy}, 24'h3);
   accept_pin = 0;
   step(6);
   hb_we = 1;
   step(1);
   hb_we = 0;
   step(100);
   check(hb_rdata_ff, 18'h2AB5C);
   accept_pin = 1;
   step(8);
   check(l1_error, 24'h1);
   {accept_pin, qual_pin} = 2'h0;
   step(6);
   resume = 1;
   step(1);
   resume = 0;
   step(1);
   check(frozen, 24'h0);
   sw_trig = 1;
   step(1);
   sw_trig = 0;
   step(2);
   check(frozen, 24'h1);
   resume = 1;
   step(1);
   resume = 0;
   sink_mode = 2'h2;
   step(112);
   check(link_drop, 24'h1);
   sink_mode = 2'h1;
   step(150);
   sink_mode = 2'h0;
   step(100);
   init_pin = 1;
   wait_ack;
   check(n >= 12 && n <= 16, 24'h1);
   init_pin = 0;
   step(2);
   check({l1_error, link_drop}, 24'h0);
   raw_send_en = 1;
   src_sel = 2'h2;
   accept_pin = 1;
   step(6);
   check(l1_busy, 24'h1);
   accept_pin = 0;
   // queued frames drain first; sixteen reach well past the burst
   n = 0;
   for (i = 0; i < 16; i = i + 1)
   begin
      next_frame(w);
      n = n + w[22];
      if (w[22])
         check(w[9:0], adc_data);
   end
   check(n, 24'h2);
   check({l1_busy, frozen}, 24'h0);
   // generator and crossing count both restart at init
   p = `TTF_PRNG_RST;
   for (i = 0; i < w[21:10]; i = i + 1)
      p = (p >> 1) ^ (p[0] ? `TTF_PRNG_POLY : 16'h0000);
   check(w[7:0], p[7:0]);
   w[15:0] = turn_count;
   turn_pin = 1;
   step(8);
   turn_pin = 0;
   check(turn_count, w[15:0] + 16'h0001);
   give_verdict;
end
endmodule
